//--- core/timer_pwm_carrier.sv
// Purpose: eight-bit compare timer with interval, pwm and carrier modes
// Assumes: AXI4-Lite register access, partner event is a same-clock pulse
// Notes: carrier mode exists only when HAS_CARRIER is set
// Summary of operation
// - interval count starts within one count clock
// - interval match clears, toggles output, interrupts
// - stopping forces interrupt and output inactive, except carrier pin with select clear, which follows slave
// - pwm period match clears, interrupts, output active
// - pwm duty match drops output, no clear
// - pwm period N+1, active width M+1
// - pwm masks first count clock after enable
// - running duty write latched in pwm and carrier, applied at first duty match after three count clocks
// - low compare rewritten at once, high compare rewritable via latch
// - select and gate choose low, high, carrier
// - gate is master/slave pair, slave read-only
// - slave takes master second clock after event
// - carrier alternates low and high compares
// - carrier reaches pin only while slave set or its high pulse is held
// - carrier period N+M+2, high width M+1
// - carrier starts inactive, inverts on each match
// - slave drop keeps pin high until fall
`timescale 1ns/1ns
`include "timer_defines.svh"

module timer_pwm_carrier #(
  parameter int ADDR_W = 8,
  parameter bit HAS_CARRIER = 1'b1
) (
  input logic clk,
  input logic rst_n,
  input logic [ADDR_W-1:0] awaddr,
  input logic awvalid,
  output logic awready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic wvalid,
  output logic wready,
  output timer_pkg::axi_resp_t bresp,
  output logic bvalid,
  input logic bready,
  input logic [ADDR_W-1:0] araddr,
  input logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output timer_pkg::axi_resp_t rresp,
  output logic rvalid,
  input logic rready,
  input logic partnerPeriodEvent,
  output logic timerOutputPin,
  output logic matchInterrupt
);
  import timer_pkg::*;

  // bus slave state
  logic awHeld_q;
  logic [ADDR_W-1:0] awAddr_q;
  logic wHeld_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic bvalid_q;
  axi_resp_t bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  axi_resp_t rresp_q;

  // software visible registers and duty transfer state
  logic [7:0] mode_q;
  logic [7:0] period_q;
  logic [7:0] dutyWritten_q;
  logic [7:0] dutyActive_q;
  logic dutyPend_q;
  logic [1:0] dutyAge_q;
  logic remoteSelect_q;
  logic gateMaster_q;
  logic gateSlave_q;

  // timer core state
  logic [7:0] counter_q;
  logic compareSel_q;
  logic outLevel_q;
  logic armed_q;
  logic irq_q;
  logic eventPend_q;
  logic synced_q;
  logic syncedPrev_q;
  logic holdHigh_q;
  logic pin_q;

  logic countTick;

  count_clock_divider u_divider (
    .clk(clk),
    .rst_n(rst_n),
    .clockSelect(mode_q[`MODE_CKS_MSB:`MODE_CKS_LSB]),
    .countTick(countTick)
  );

  function automatic logic [7:0] wordAddr(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] aligned;
    aligned = {a[ADDR_W-1:2], 2'b00};
    return aligned[7:0];
  endfunction

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    logic [7:0] w;
    w = wordAddr(a);
    return (w == `OFS_MODE) || (w == `OFS_PERIOD) || (w == `OFS_DUTY) ||
           (w == `OFS_CARRIER) || (w == `OFS_STATUS);
  endfunction

  // ---- write channel decode ----
  wire doWrite = awHeld_q && wHeld_q && !bvalid_q;
  wire [7:0] wrWord = wordAddr(awAddr_q);
  wire wrLane = wStrb_q[0];
  wire wrMode = doWrite && wrLane && (wrWord == `OFS_MODE);
  wire wrPeriod = doWrite && wrLane && (wrWord == `OFS_PERIOD);
  wire wrDuty = doWrite && wrLane && (wrWord == `OFS_DUTY);
  wire wrCarrier = doWrite && wrLane && (wrWord == `OFS_CARRIER);
  wire wrMapped = isMapped(awAddr_q);

  assign awready = !awHeld_q && !bvalid_q;
  assign wready = !wHeld_q && !bvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  // ---- mode decode ----
  wire running = mode_q[`MODE_RUN_BIT];
  wire [1:0] modeField = mode_q[`MODE_MD_MSB:`MODE_MD_LSB];
  wire isCarrier = HAS_CARRIER && (modeField == MODE_CARRIER);
  wire isPwm = (modeField == MODE_PWM);
  wire isInterval = !isCarrier && !isPwm;
  wire idleLevel = mode_q[`MODE_LEV_BIT];
  wire outEnable = mode_q[`MODE_OEN_BIT];

  // while running only the run bit may change
  wire [7:0] modeNext = running ? {wData_q[`MODE_RUN_BIT], mode_q[6:0]} : wData_q[7:0];

  // ---- compare engine ----
  wire [7:0] compareValue = compareSel_q ? dutyActive_q : period_q;
  wire hit = (counter_q == compareValue);
  // pwm masks the first count clock after enable
  wire countGo = running && countTick && (armed_q || !isPwm);
  wire dutyHit = countGo && hit && compareSel_q;
  wire clearHit = countGo && hit && !(isPwm && compareSel_q);
  wire irqHit = clearHit;
  wire selFlip = countGo && hit && !isInterval;
  // pwm: period match drives active, duty match inactive; others invert
  wire outNext = isPwm ? !compareSel_q : !outLevel_q;
  wire [7:0] counterNext = clearHit ? 8'h00 : counter_q + 8'h01;

  // ---- duty / high-width latch ----
  wire latchWrite = wrDuty && running && !isInterval;
  wire dutyXfer = dutyHit && dutyPend_q && (dutyAge_q == `DUTY_XFER_CLOCKS);

  // ---- gate transfer ----
  wire eventPendNext = partnerPeriodEvent || (eventPend_q && !countTick);
  wire gateXfer = countTick && synced_q && !syncedPrev_q;
  wire holdHighNext = outLevel_q && (holdHigh_q || gateSlave_q);

  // ---- pin selection ----
  wire carrierGated = outLevel_q && (gateSlave_q || holdHigh_q);
  wire carrierLevel = remoteSelect_q ? carrierGated : gateSlave_q;
  wire timerLevel = outLevel_q ^ idleLevel;
  wire pinNext = !outEnable ? idleLevel : (isCarrier ? carrierLevel : timerLevel);

  // ---- read decode ----
  wire [7:0] rdWord = wordAddr(araddr);
  wire [31:0] statusWord = {20'h00000, pin_q, dutyPend_q, compareSel_q, outLevel_q, counter_q};
  wire [31:0] carrierWord = {29'h0, remoteSelect_q, gateMaster_q, gateSlave_q};
  wire [31:0] readMux = (rdWord == `OFS_MODE) ? {24'h000000, mode_q} :
                        (rdWord == `OFS_PERIOD) ? {24'h000000, period_q} :
                        (rdWord == `OFS_DUTY) ? {24'h000000, dutyWritten_q} :
                        (rdWord == `OFS_CARRIER) ? carrierWord :
                        (rdWord == `OFS_STATUS) ? statusWord :
                        32'h00000000;
  wire takeRead = arvalid && !rvalid_q;

  assign arready = !rvalid_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  // ---- bus write side ----
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_q <= 1'b0;
      awAddr_q <= '0;
      wHeld_q <= 1'b0;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld_q <= 1'b1;
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ---- bus read side ----
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else if (takeRead) begin
      rvalid_q <= 1'b1;
      rdata_q <= readMux;
      rresp_q <= isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---- control registers ----
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= `MODE_RESET;
      period_q <= `CMP_RESET;
      remoteSelect_q <= 1'b0;
      gateMaster_q <= 1'b0;
    end else begin
      if (wrMode) begin
        mode_q <= modeNext;
      end
      if (wrPeriod) begin
        period_q <= wData_q[7:0];
      end
      if (wrCarrier) begin
        remoteSelect_q <= wData_q[`CAR_SELECT_BIT];
        gateMaster_q <= wData_q[`CAR_MASTER_BIT];
      end
    end
  end

  // ---- duty compare with transfer latch ----
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dutyWritten_q <= `CMP_RESET;
      dutyActive_q <= `CMP_RESET;
      dutyPend_q <= 1'b0;
      dutyAge_q <= 2'd0;
    end else if (wrDuty) begin
      dutyWritten_q <= wData_q[7:0];
      dutyPend_q <= latchWrite;
      dutyAge_q <= 2'd0;
      if (!latchWrite) begin
        dutyActive_q <= wData_q[7:0];
      end
    end else begin
      if (countTick && dutyPend_q && dutyAge_q != `DUTY_XFER_CLOCKS) begin
        dutyAge_q <= dutyAge_q + 2'd1;
      end
      if (dutyXfer) begin
        dutyActive_q <= dutyWritten_q;
        dutyPend_q <= 1'b0;
      end
    end
  end

  // ---- counter, compare select and output level ----
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      counter_q <= 8'h00;
      compareSel_q <= 1'b0;
      outLevel_q <= 1'b0;
      armed_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (!running) begin
      counter_q <= 8'h00;
      compareSel_q <= 1'b0;
      outLevel_q <= 1'b0;
      armed_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      irq_q <= irqHit;
      if (countTick) begin
        armed_q <= 1'b1;
      end
      if (countGo) begin
        counter_q <= counterNext;
        if (hit) begin
          outLevel_q <= outNext;
        end
        if (selFlip) begin
          compareSel_q <= !compareSel_q;
        end
      end
    end
  end

  // ---- partner event sync and gate transfer ----
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eventPend_q <= 1'b0;
      synced_q <= 1'b0;
      syncedPrev_q <= 1'b0;
      gateSlave_q <= 1'b0;
    end else begin
      eventPend_q <= eventPendNext;
      if (countTick) begin
        synced_q <= eventPend_q;
        syncedPrev_q <= synced_q;
      end
      if (gateXfer) begin
        gateSlave_q <= gateMaster_q;
      end
    end
  end

  // ---- output pin ----
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      holdHigh_q <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      holdHigh_q <= holdHighNext;
      pin_q <= pinNext;
    end
  end

  assign timerOutputPin = pin_q;
  assign matchInterrupt = irq_q;

endmodule

//--- core/timer_defines.svh
// Purpose: offsets, field positions, reset values and counts of the compare timer
// Assumes: 32-bit register bus, one aligned word per register
// Notes: definitions only
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// register byte offsets
`define OFS_MODE 8'h00
`define OFS_PERIOD 8'h04
`define OFS_DUTY 8'h08
`define OFS_CARRIER 8'h0c
`define OFS_STATUS 8'h10

// timer_mode_register fields
`define MODE_RUN_BIT 7
`define MODE_CKS_MSB 6
`define MODE_CKS_LSB 4
`define MODE_MD_MSB 3
`define MODE_MD_LSB 2
`define MODE_LEV_BIT 1
`define MODE_OEN_BIT 0

// carrier_control_register fields
`define CAR_SELECT_BIT 2
`define CAR_MASTER_BIT 1
`define CAR_SLAVE_BIT 0

// status register fields
`define STAT_OUT_BIT 8
`define STAT_SEL_BIT 9
`define STAT_PEND_BIT 10
`define STAT_PIN_BIT 11

// reset values
`define MODE_RESET 8'h00
`define CMP_RESET 8'h00

// count clocks a duty rewrite needs before its transfer
`define DUTY_XFER_CLOCKS 2'd3

// count clock divider: log2 of the ratio for each select code
`define CKS_DIV0_LOG2 0
`define CKS_DIV1_LOG2 2
`define CKS_DIV2_LOG2 4
`define CKS_DIV3_LOG2 6
`define CKS_DIV4_LOG2 12
`define CKS_DIV5_LOG2 7
`define PRESCALE_BITS 12

`endif

//--- core/timer_pkg.sv
// Purpose: shared types of the compare timer
// Assumes: nothing
// Notes: mode codes follow the mode field of the mode register
package timer_pkg;

  typedef enum logic [1:0] {
    MODE_INTERVAL = 2'b00,
    MODE_CARRIER = 2'b01,
    MODE_PWM = 2'b10
  } timer_mode_t;

  typedef enum logic [1:0] {
    RESP_OKAY = 2'b00,
    RESP_SLVERR = 2'b10
  } axi_resp_t;

endpackage

//--- core/count_clock_divider.sv
// Purpose: count clock enable from the system clock
// Assumes: countTick is a one-cycle enable at the selected rate
// Notes: codes 6 and 7 give no tick at all
`timescale 1ns/1ns
`include "timer_defines.svh"

module count_clock_divider (
  input logic clk,
  input logic rst_n,
  input logic [2:0] clockSelect,
  output logic countTick
);
  import timer_pkg::*;

  logic [`PRESCALE_BITS-1:0] prescale_q;
  logic tick_q;
  logic tickNow;

  // true when the low lg bits of the prescaler are all ones
  function automatic logic allOnes(input logic [`PRESCALE_BITS-1:0] v, input int lg);
    logic r;
    r = 1'b1;
    for (int i = 0; i < `PRESCALE_BITS; i++) begin
      if (i < lg && !v[i]) begin
        r = 1'b0;
      end
    end
    return r;
  endfunction

  assign tickNow = (clockSelect == 3'h0) ? allOnes(prescale_q, `CKS_DIV0_LOG2) :
                   (clockSelect == 3'h1) ? allOnes(prescale_q, `CKS_DIV1_LOG2) :
                   (clockSelect == 3'h2) ? allOnes(prescale_q, `CKS_DIV2_LOG2) :
                   (clockSelect == 3'h3) ? allOnes(prescale_q, `CKS_DIV3_LOG2) :
                   (clockSelect == 3'h4) ? allOnes(prescale_q, `CKS_DIV4_LOG2) :
                   (clockSelect == 3'h5) ? allOnes(prescale_q, `CKS_DIV5_LOG2) :
                   1'b0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prescale_q <= '0;
      tick_q <= 1'b0;
    end else begin
      prescale_q <= prescale_q + 1'b1;
      tick_q <= tickNow;
    end
  end

  assign countTick = tick_q;

endmodule

//--- tb/partner_counter.sv
// Purpose: event counter on the far side, one period event pulse per interval
// Assumes: its count clock is clk divided by TICK_DIV
// Notes: the event line rests low between pulses
`timescale 1ns/1ns
module partner_counter #(
  parameter int TICK_DIV = 8,
  parameter int EVENT_TICKS = 4
) (
  input logic clk,
  input logic rst_n,
  input logic partnerRun,
  output logic partnerPeriodEvent
);
  int divCnt_q;
  int tickCnt_q;
  // count clock is clk/8, so the timer runs eight times faster
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_q <= 0;
      tickCnt_q <= 0;
      partnerPeriodEvent <= 1'b0;
    end else begin
      partnerPeriodEvent <= 1'b0;
      if (partnerRun) begin
        divCnt_q <= (divCnt_q == TICK_DIV - 1) ? 0 : divCnt_q + 1;
        if (divCnt_q == TICK_DIV - 1) begin
          tickCnt_q <= (tickCnt_q == EVENT_TICKS - 1) ? 0 : tickCnt_q + 1;
          partnerPeriodEvent <= (tickCnt_q == EVENT_TICKS - 1);
        end
      end
    end
  end
endmodule

//--- tb/timer_chk.sv
// Purpose: port-level checks of the compare timer
// Assumes: write address and data offered together
// Notes: bound into every timer_pwm_carrier
`timescale 1ns/1ns
module timer_chk #(
  parameter int ADDR_W = 8
) (
  input logic clk,
  input logic rst_n,
  input logic [ADDR_W-1:0] awaddr,
  input logic awvalid,
  input logic awready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic wvalid,
  input logic wready,
  input timer_pkg::axi_resp_t bresp,
  input logic bvalid,
  input logic bready,
  input logic [ADDR_W-1:0] araddr,
  input logic arvalid,
  input logic arready,
  input logic [31:0] rdata,
  input timer_pkg::axi_resp_t rresp,
  input logic rvalid,
  input logic rready,
  input logic partnerPeriodEvent,
  input logic timerOutputPin,
  input logic matchInterrupt
);
  import timer_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire awTake = awvalid && awready && wvalid && wready;
  // stop written outside carrier mode
  sequence stopWrite;
    awTake && awaddr[7:2] == 6'h00 && wstrb[0] && !wdata[7] && wdata[3:2] != 2'b01;
  endsequence
  chk_irq_single: assert property (matchInterrupt |=> !matchInterrupt)
    else $error("interrupt longer than one cycle");
  chk_stop_irq: assert property (stopWrite |-> ##3 !matchInterrupt [*4])
    else $error("interrupt after stop");
  chk_stop_pin: assert property (stopWrite |-> ##5 $stable(timerOutputPin) [*2])
    else $error("pin moves after stop");
  chk_wr_answer: assert property (awTake |-> ##[1:2] bvalid)
    else $error("no write response");
  chk_rd_answer: assert property (arvalid && arready |=> rvalid)
    else $error("no read response");
  chk_wr_refuse: assert property (bvalid |-> !awready && !wready)
    else $error("write taken during response");
  chk_rd_refuse: assert property (rvalid |-> !arready)
    else $error("read taken during response");
  chk_bad_addr: assert property (awTake && awaddr[7:2] > 6'h04 |-> ##[1:2] bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
endmodule
bind timer_pwm_carrier timer_chk #(.ADDR_W(ADDR_W)) timer_chk_i (.clk, .rst_n, .awaddr,
  .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
  .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .partnerPeriodEvent, .timerOutputPin,
  .matchInterrupt);

//--- tb/timer_pwm_carrier_tb.sv
// Purpose: register-driven test of the compare timer in all three modes
// Assumes: clock select 0, one count clock per clk
// Notes: bready and rready stay high
`timescale 1ns/1ns
module timer_pwm_carrier_tb;
  import timer_pkg::*;
  logic clk, rst_n, awvalid, wvalid, arvalid, partnerRun, sel, mst;
  logic awready, wready, bvalid, arready, rvalid, partnerPeriodEvent, timerOutputPin;
  logic matchInterrupt;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  axi_resp_t bresp, rresp, lastResp;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  int hi, lo, irqs;
  int expHi[4] = '{0, 28, 0, 16};
  timer_pwm_carrier timer_pwm_carrier_i (.clk(clk), .rst_n(rst_n), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(1'b1), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(1'b1), .partnerPeriodEvent(partnerPeriodEvent), .timerOutputPin(timerOutputPin),
    .matchInterrupt(matchInterrupt));
  partner_counter partner_counter_i (.clk(clk), .rst_n(rst_n), .partnerRun(partnerRun),
    .partnerPeriodEvent(partnerPeriodEvent));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    lastResp = bresp;
  endtask
  task automatic rdReg(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    forever begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rd = rdata;
    lastResp = rresp;
  endtask
  // widths of one high and the following low phase of the pin
  task automatic pinWidths();
    hi = 0;
    lo = 0;
    irqs = 0;
    @(posedge clk);
    while (timerOutputPin !== 1'b0) @(posedge clk);
    while (timerOutputPin !== 1'b1) @(posedge clk);
    while (timerOutputPin === 1'b1) begin
      hi++;
      irqs += (matchInterrupt === 1'b1);
      @(posedge clk);
    end
    while (timerOutputPin === 1'b0) begin
      lo++;
      irqs += (matchInterrupt === 1'b1);
      @(posedge clk);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    rst_n = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    partnerRun = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      rdReg(8'(i * 4));
      check("reset value", rd, 32'h0);
    end
    rdReg(8'h14);
    check("read unmapped", lastResp, RESP_SLVERR);
    wr(8'h14, 32'h1);
    check("write unmapped", lastResp, RESP_SLVERR);
    wr(8'h04, 32'h3);
    wr(8'h00, 32'h81);
    pinWidths();
    check("interval high", hi, 4);
    check("interval low", lo, 4);
    check("interval irqs", irqs, 2);
    wr(8'h00, 32'h01);
    repeat (4) @(posedge clk);
    check("stopped pin", timerOutputPin, 1'b0);
    check("stopped irq", matchInterrupt, 1'b0);
    rdReg(8'h10);
    check("stopped count", rd[7:0], 8'h00);
    wr(8'h04, 32'h5);
    wr(8'h08, 32'h2);
    wr(8'h00, 32'h89);
    check("pwm start pin", timerOutputPin, 1'b0);
    pinWidths();
    check("pwm high", hi, 3);
    check("pwm low", lo, 3);
    check("pwm irqs", irqs, 1);
    wr(8'h08, 32'h4);
    pinWidths();
    pinWidths();
    check("pwm new high", hi, 5);
    check("pwm new low", lo, 1);
    wr(8'h00, 32'h09);
    wr(8'h04, 32'h2);
    wr(8'h08, 32'h3);
    wr(8'h00, 32'h85);
    partnerRun <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      sel = i[1];
      mst = i[0];
      wr(8'h0c, 32'({sel, mst, 1'b0}));
      repeat (80) @(posedge clk);
      rdReg(8'h0c);
      check("gate bits", rd, 32'({sel, mst, mst}));
      hi = 0;
      repeat (28) begin
        @(posedge clk);
        hi += (timerOutputPin === 1'b1);
      end
      check("gated highs", hi, expHi[i]);
    end
    pinWidths();
    check("carrier high", hi, 4);
    check("carrier low", lo, 3);
    check("carrier irqs", irqs, 2);
    // close the gate mid-run: every high pulse must stay full width
    wr(8'h0c, 32'h4);
    hi = 0;
    repeat (60) begin
      @(posedge clk);
      if (timerOutputPin === 1'b1) begin
        hi++;
      end else begin
        if (hi != 0) check("held high width", hi, 4);
        hi = 0;
      end
    end
    check("gate closed pin", timerOutputPin, 1'b0);
    give_verdict();
  end
endmodule
